// File: rtl/ect_map.svh
// Register offsets, field positions, reset values for the compare timer
`ifndef ECT_MAP_SVH
`define ECT_MAP_SVH

// Register offsets on the 3-bit register port
`define ECT_OFF_COUNTER   3'h0
`define ECT_OFF_CONST_A   3'h1
`define ECT_OFF_CONST_B   3'h2
`define ECT_OFF_MAIN_CTL  3'h3
`define ECT_OFF_FLAGS     3'h4
`define ECT_OFF_TRIG_CLK  3'h5

// Main control fields
`define ECT_MC_MB_IE      7
`define ECT_MC_MA_IE      6
`define ECT_MC_OV_IE      5
`define ECT_MC_CLR_HI     4
`define ECT_MC_CLR_LO     3
`define ECT_MC_CKS_HI     2
`define ECT_MC_CKS_LO     0

// Flags and output select fields
`define ECT_FL_MB         7
`define ECT_FL_MA         6
`define ECT_FL_OV         5
`define ECT_FL_RSV        4
`define ECT_FL_OSB_HI     3
`define ECT_FL_OSB_LO     2
`define ECT_FL_OSA_HI     1
`define ECT_FL_OSA_LO     0

// Trigger and clock control fields
`define ECT_TC_EDGE_HI    4
`define ECT_TC_EDGE_LO    3
`define ECT_TC_TRIGGER_ENABLE       2
`define ECT_TC_ICKS       0
`define ECT_TC_RSV_MASK   8'hE2

// Reset values
`define ECT_RST_COUNTER   8'h00
`define ECT_RST_CONST     8'hFF
`define ECT_RST_CTL       8'h00

// Prescaler width: taps for system clock over 4 up to over 128
`define ECT_PRE_W         7

`endif

// File: rtl/ect_pkg.sv
// Types shared by the compare timer
package ect_pkg;
    // Pin action on a compare match
    typedef enum logic [1:0] {
        ECT_ACT_KEEP   = 2'b00,
        ECT_ACT_LOW    = 2'b01,
        ECT_ACT_HIGH   = 2'b10,
        ECT_ACT_TOGGLE = 2'b11
    } ect_action_t;
    // Counter clear source
    typedef enum logic [1:0] {
        ECT_CLR_NONE  = 2'b00,
        ECT_CLR_MA    = 2'b01,
        ECT_CLR_MB    = 2'b10,
        ECT_CLR_PIN   = 2'b11
    } ect_clear_t;
    // Trigger edge select
    typedef enum logic [1:0] {
        ECT_TRG_OFF   = 2'b00,
        ECT_TRG_RISE  = 2'b01,
        ECT_TRG_FALL  = 2'b10,
        ECT_TRG_BOTH  = 2'b11
    } ect_edge_t;
endpackage : ect_pkg

// File: rtl/ect_timer.sv
// Eight-bit compare timer with waveform output, trigger and clear inputs
//
// Functional notes
// - Match B flag sets; read-1-then-write-0 clears
// - Match A flag sets; read-1-then-write-0 clears
// - Overflow flag on FF to 00 wrap
// - Flags register bit 4 reads one
// - Bits 3:2 pick pin action on match B
// - Bits 1:0 pick pin action on match A
// - Independent actions; pin low until first match
// - Trigger edge field: off, rise, fall, both
// - Trigger enable: start on edge, halt on clear
// - Trigger register bits 7:5 and 1 read one
// - Extra clock select bit picks prescaler tap
// - Count on active edges of selected source
// - Overflow request when flag and enable set
// - Match made in last equal state
// - Match requests when flag and enable set
// - Pin takes selected level or toggles on match
// - Clear select 01/10 clears on match A/B
// - Clear select 11 clears on reset pin rise
// - With trigger enable, clear halts until edge
// - Eight-bit up counter, software read/write
// - Compare constants reset to all ones
// - Prescaler taps, external edges, 000/100 stop
// - Interrupt enables at control bits 7, 6, 5
`timescale 1ns/1ps
`include "ect_map.svh"

module ect_timer
    import ect_pkg::*;
(
    input  wire logic       REF_CLK_IN,      // System clock, 100 MHz
    input  wire logic       RESET_N_IN,      // Synchronous reset, low
    input  wire logic [2:0] ADDR_IN,         // Register address
    input  wire logic [7:0] WDATA_IN,        // Write data
    input  wire logic       WR_IN,           // Write strobe
    input  wire logic       RD_IN,           // Read strobe
    output logic      [7:0] RDATA_OUT,       // Read data, next cycle
    input  wire logic       EXT_CLOCK_IN,    // External count clock pin
    input  wire logic       COUNTER_RESET_IN,// External counter reset pin
    input  wire logic       COUNT_TRIGGER_IN,// Count trigger pin
    output logic            WAVEFORM_OUT,    // Waveform output pin
    output logic            IRQ_MATCH_A_OUT, // Match A request
    output logic            IRQ_MATCH_B_OUT, // Match B request
    output logic            IRQ_OVERFLOW_OUT // Overflow request
);

    // Software visible registers
    logic [7:0] up_counter_reg;          // Counter
    logic [7:0] compare_constant_a_reg;  // Constant A
    logic [7:0] compare_constant_b_reg;  // Constant B
    logic [7:0] timer_main_control_reg;  // Enables, clear, clock select
    logic [2:0] flags_reg;               // Match B, match A, overflow
    logic [3:0] out_select_reg;          // Match B and A actions
    logic [2:0] trig_ctl_reg;            // Edge select and enable
    logic       extra_clock_select_reg;  // Extra tap select bit
    logic [7:0] rdata_reg;               // Read data holder

    // Internal state
    logic [2:0] armed_reg;               // Flag seen as one by a read
    logic [`ECT_PRE_W-1:0] prescale_reg; // Free running divider
    logic       tap_prev_reg;            // Previous tap level
    logic       waveform_reg;            // Output pin level
    logic       run_reg;                 // Trigger run state

    // Two-flop synchronisers and edge history for the three pins
    logic [1:0] ext_sync_reg;            // External clock sync
    logic [1:0] rst_sync_reg;            // Reset pin sync
    logic [1:0] trg_sync_reg;            // Trigger pin sync
    logic       ext_prev_reg;            // Synced clock, delayed
    logic       rst_prev_reg;            // Synced reset pin, delayed
    logic       trg_prev_reg;            // Synced trigger, delayed

    // Register decode
    wire        wr_counter  = WR_IN && (ADDR_IN == `ECT_OFF_COUNTER);
    wire        wr_const_a  = WR_IN && (ADDR_IN == `ECT_OFF_CONST_A);
    wire        wr_const_b  = WR_IN && (ADDR_IN == `ECT_OFF_CONST_B);
    wire        wr_main     = WR_IN && (ADDR_IN == `ECT_OFF_MAIN_CTL);
    wire        wr_flags    = WR_IN && (ADDR_IN == `ECT_OFF_FLAGS);
    wire        wr_trig     = WR_IN && (ADDR_IN == `ECT_OFF_TRIG_CLK);

    // Flags read arms
    wire        rd_flags    = RD_IN && (ADDR_IN == `ECT_OFF_FLAGS);

    // Control fields
    wire [2:0]  clock_sel   = timer_main_control_reg[`ECT_MC_CKS_HI:`ECT_MC_CKS_LO];
    wire        clr_hi      = timer_main_control_reg[`ECT_MC_CLR_HI];
    wire        clr_lo      = timer_main_control_reg[`ECT_MC_CLR_LO];
    // Typed fields
    wire ect_clear_t clear_sel = ect_clear_t'({clr_hi, clr_lo});
    wire ect_edge_t  trig_edge = ect_edge_t'(trig_ctl_reg[2:1]);
    wire        trigger_enable = trig_ctl_reg[0];
    // Pin actions
    wire ect_action_t act_b = ect_action_t'(out_select_reg[3:2]);
    wire ect_action_t act_a = ect_action_t'(out_select_reg[1:0]);

    // Prescaler tap choice from clock select and extra bit
    logic [2:0] tap_index;               // Divider bit feeding the counter
    always_comb begin
        // Tap pairs
        unique case (clock_sel[1:0])
            2'b01:   tap_index = extra_clock_select_reg ? 3'h2 : 3'h1;
            2'b10:   tap_index = extra_clock_select_reg ? 3'h4 : 3'h3;
            2'b11:   tap_index = extra_clock_select_reg ? 3'h6 : 3'h5;
            default: tap_index = 3'h1;   // Code 00 counts nothing
        endcase
    end

    // Tap level and its falling edge
    wire        tap_now     = prescale_reg[tap_index];
    wire        tap_fall    = tap_prev_reg && !tap_now;

    // External clock edges after synchronisation
    wire        ext_rise    = ext_sync_reg[1] && !ext_prev_reg;
    wire        ext_fall    = !ext_sync_reg[1] && ext_prev_reg;

    // Count tick per clock source; 000 and 100 inhibit
    logic       source_tick;             // Active edge of chosen source
    always_comb begin
        // Source pick
        unique case (clock_sel)
            3'b001, 3'b010, 3'b011: source_tick = tap_fall;
            3'b101:  source_tick = ext_rise;
            3'b110:  source_tick = ext_fall;
            3'b111:  source_tick = ext_rise || ext_fall;
            default: source_tick = 1'b0; // Clock input prohibited
        endcase
    end

    // Trigger pin edges filtered by the edge field
    wire        trg_rise    = trg_sync_reg[1] && !trg_prev_reg;
    wire        trg_fall    = !trg_sync_reg[1] && trg_prev_reg;

    // Selected edge
    wire        trig_hit    = ((trig_edge == ECT_TRG_RISE) && trg_rise) ||
                              ((trig_edge == ECT_TRG_FALL) && trg_fall) ||
                              ((trig_edge == ECT_TRG_BOTH) && (trg_rise || trg_fall));

    // Counting allowed: free running, or running after a trigger
    wire        count_ok    = !trigger_enable || run_reg;
    wire        tick        = source_tick && count_ok;

    // Compare match fires as the counter leaves the equal value
    wire        eq_a        = (up_counter_reg == compare_constant_a_reg);
    wire        eq_b        = (up_counter_reg == compare_constant_b_reg);

    // Write masks match
    wire        match_a     = eq_a && tick && !wr_const_a;
    wire        match_b     = eq_b && tick && !wr_const_b;

    // Clear sources
    wire        pin_rise    = rst_sync_reg[1] && !rst_prev_reg;
    wire        clr_by_a    = (clear_sel == ECT_CLR_MA) && match_a;
    wire        clr_by_b    = (clear_sel == ECT_CLR_MB) && match_b;
    wire        clr_by_pin  = (clear_sel == ECT_CLR_PIN) && pin_rise;

    // Any clear
    wire        clear_now   = clr_by_a || clr_by_b || clr_by_pin;

    // Overflow when an increment wraps all ones
    wire        overflow    = tick && (up_counter_reg == 8'hFF) && !clear_now;

    // Counter next value: clear, then write, then increment
    logic [7:0] counter_next;            // Next counter value
    always_comb begin
        // Clear first
        if (clear_now) begin
            counter_next = `ECT_RST_COUNTER;
        end else if (wr_counter) begin
            // Load
            counter_next = WDATA_IN;
        end else if (tick) begin
            // Step
            counter_next = up_counter_reg + 8'h01;
        end else begin
            // Hold
            counter_next = up_counter_reg;
        end
    end

    // Flag events in bit order match B, match A, overflow
    wire [2:0]  flag_set    = {match_b, match_a, overflow};
    // Zero bits clear
    wire [2:0]  wr_zero     = ~WDATA_IN[`ECT_FL_MB:`ECT_FL_OV];
    wire [2:0]  flag_clear  = {3{wr_flags}} & wr_zero & armed_reg;
    wire [2:0]  flags_next  = flag_set | (flags_reg & ~flag_clear);

    // Arm a flag when a read shows it as one; a flags write disarms
    logic [2:0] armed_next;              // Next arm state
    always_comb begin
        if (wr_flags) begin
            // Disarm all
            armed_next = 3'b000;
        end else if (rd_flags) begin
            armed_next = armed_reg | flags_reg;
        end else begin
            // Keep
            armed_next = armed_reg;
        end
    end

    // Pin level for one match action
    function automatic logic apply_action(input ect_action_t act, input logic cur);
        // Shared encoding
        unique case (act)
            ECT_ACT_KEEP:   apply_action = cur;
            ECT_ACT_LOW:    apply_action = 1'b0;
            ECT_ACT_HIGH:   apply_action = 1'b1;
            ECT_ACT_TOGGLE: apply_action = !cur;
        endcase
    endfunction : apply_action

    // Pin update; a coincident pair resolves toggle over one over zero
    logic       waveform_next;           // Next pin level
    always_comb begin
        if (match_a && match_b) begin
            // Priority pick
            if (act_a == ECT_ACT_TOGGLE || act_b == ECT_ACT_TOGGLE) begin
                waveform_next = !waveform_reg;
            end else if (act_a == ECT_ACT_HIGH || act_b == ECT_ACT_HIGH) begin
                waveform_next = 1'b1;
            end else if (act_a == ECT_ACT_LOW || act_b == ECT_ACT_LOW) begin
                waveform_next = 1'b0;
            end else begin
                waveform_next = waveform_reg;
            end
        end else if (match_a) begin
            waveform_next = apply_action(act_a, waveform_reg);
        end else if (match_b) begin
            waveform_next = apply_action(act_b, waveform_reg);
        end else begin
            waveform_next = waveform_reg;
        end
    end

    // Trigger run state: edge starts, any clear halts
    logic       run_next;                // Next run state
    always_comb begin
        if (!trigger_enable) begin
            // Free running
            run_next = 1'b0;
        end else if (clear_now) begin
            run_next = 1'b0;
        end else if (trig_hit) begin
            run_next = 1'b1;
        end else begin
            // Keep
            run_next = run_reg;
        end
    end

    // Read multiplexer; reserved bits read one, unmapped reads zero
    logic [7:0] read_mux;                // Selected register
    always_comb begin
        unique case (ADDR_IN)
            `ECT_OFF_COUNTER:  read_mux = up_counter_reg;
            `ECT_OFF_CONST_A:  read_mux = compare_constant_a_reg;
            `ECT_OFF_CONST_B:  read_mux = compare_constant_b_reg;
            `ECT_OFF_MAIN_CTL: read_mux = timer_main_control_reg;
            `ECT_OFF_FLAGS:    read_mux = {flags_reg, 1'b1, out_select_reg};
            `ECT_OFF_TRIG_CLK: read_mux = `ECT_TC_RSV_MASK |
                                          {3'h0, trig_ctl_reg, 1'b0, extra_clock_select_reg};
            // Unmapped
            default:           read_mux = 8'h00;
        endcase
    end

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            ext_sync_reg <= 2'b00;
            rst_sync_reg <= 2'b00;
            trg_sync_reg <= 2'b00;
            ext_prev_reg <= 1'b0;
            rst_prev_reg <= 1'b0;
            trg_prev_reg <= 1'b0;
        end else begin
            // Shift in
            ext_sync_reg <= {ext_sync_reg[0], EXT_CLOCK_IN};
            rst_sync_reg <= {rst_sync_reg[0], COUNTER_RESET_IN};
            trg_sync_reg <= {trg_sync_reg[0], COUNT_TRIGGER_IN};
            // Edge history
            ext_prev_reg <= ext_sync_reg[1];
            rst_prev_reg <= rst_sync_reg[1];
            trg_prev_reg <= trg_sync_reg[1];
        end
    end

    // Prescaler and tap history
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            prescale_reg <= '0;
            tap_prev_reg <= 1'b0;
        end else begin
            // Free divider
            prescale_reg <= prescale_reg + 1'b1;
            tap_prev_reg <= tap_now;
        end
    end

    // Counter, constants and control registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            up_counter_reg         <= `ECT_RST_COUNTER;
            compare_constant_a_reg <= `ECT_RST_CONST;
            compare_constant_b_reg <= `ECT_RST_CONST;
            timer_main_control_reg <= `ECT_RST_CTL;
            // Fields clear
            out_select_reg         <= 4'h0;
            trig_ctl_reg           <= 3'h0;
            extra_clock_select_reg <= 1'b0;
        end else begin
            // Count
            up_counter_reg <= counter_next;

            // Software loads
            if (wr_const_a) begin
                compare_constant_a_reg <= WDATA_IN;
            end
            if (wr_const_b) begin
                compare_constant_b_reg <= WDATA_IN;
            end
            if (wr_main) begin
                timer_main_control_reg <= WDATA_IN;
            end
            if (wr_flags) begin
                out_select_reg <= WDATA_IN[`ECT_FL_OSB_HI:`ECT_FL_OSA_LO];
            end
            if (wr_trig) begin
                trig_ctl_reg           <= WDATA_IN[`ECT_TC_EDGE_HI:`ECT_TC_TRIGGER_ENABLE];
                extra_clock_select_reg <= WDATA_IN[`ECT_TC_ICKS];
            end
        end
    end

    // Flags, arming, pin level, run state and read data
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            // Start low
            flags_reg    <= 3'b000;
            armed_reg    <= 3'b000;
            waveform_reg <= 1'b0;
            run_reg      <= 1'b0;
            rdata_reg    <= 8'h00;
        end else begin
            // Advance state
            flags_reg    <= flags_next;
            armed_reg    <= armed_next;
            waveform_reg <= waveform_next;
            run_reg      <= run_next;

            // Read capture
            if (RD_IN) begin
                rdata_reg <= read_mux;
            end
        end
    end

    // Outputs
    assign RDATA_OUT        = rdata_reg;
    assign WAVEFORM_OUT     = waveform_reg;

    // Flag and enable
    assign IRQ_MATCH_A_OUT  = flags_reg[1] &&
                              timer_main_control_reg[`ECT_MC_MA_IE];
    assign IRQ_MATCH_B_OUT  = flags_reg[2] &&
                              timer_main_control_reg[`ECT_MC_MB_IE];
    assign IRQ_OVERFLOW_OUT = flags_reg[0] &&
                              timer_main_control_reg[`ECT_MC_OV_IE];

endmodule : ect_timer

// File: tb/ect_pins_model.sv
// Far-side model: external clock, counter reset and trigger pins
`timescale 1ns/1ps
module ect_pins_model (
    input  wire logic clk_in,      // System clock
    output logic      ext_clk_out, // External count clock
    output logic      ctr_rst_out, // Counter reset pin
    output logic      trig_out     // Count trigger pin
);
    // Pins idle low
    initial begin
        ext_clk_out = 1'b0;
        ctr_rst_out = 1'b0;
        trig_out    = 1'b0;
    end
    // Pulses of w clocks high and w low, so w picks a fast or slow source
    task ext_pulses(input int n, input int w);
        for (int k = 0; k < n; k++) begin
            repeat (w) @(posedge clk_in);
            ext_clk_out <= 1'b1;
            repeat (w) @(posedge clk_in);
            ext_clk_out <= 1'b0;
        end
    endtask : ext_pulses
    // Reset pulse held two full clocks
    task rst_pulse();
        @(posedge clk_in);
        ctr_rst_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        ctr_rst_out <= 1'b0;
    endtask : rst_pulse
    // Move the trigger pin
    task set_trig(input logic lvl);
        @(posedge clk_in);
        trig_out <= lvl;
    endtask : set_trig
endmodule : ect_pins_model

// File: tb/ect_timer_properties.sv
// Port-level checker for the compare timer, bound to its top module
`timescale 1ns/1ps
`include "ect_map.svh"
module ect_timer_checker (
    input  wire logic       REF_CLK_IN,
    input  wire logic       RESET_N_IN,
    input  wire logic [2:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    input  wire logic [7:0] RDATA_OUT,
    input  wire logic       WAVEFORM_OUT,
    input  wire logic       IRQ_MATCH_A_OUT,
    input  wire logic       IRQ_MATCH_B_OUT,
    input  wire logic       IRQ_OVERFLOW_OUT
);
    wire logic  fl_wr  = WR_IN && (ADDR_IN == `ECT_OFF_FLAGS);    // Flags write
    wire logic  fl_rd  = RD_IN && (ADDR_IN == `ECT_OFF_FLAGS);    // Flags read
    wire logic  ctl_wr = WR_IN && (ADDR_IN == `ECT_OFF_MAIN_CTL); // Control write
    logic [7:0] ctl_reg;  // Shadow of main control
    logic       seen_reg; // Flags read since last flags write
    logic       clr_reg;  // Armed flags write last cycle
    logic       cwr_reg;  // Control write last cycle
    // Follow what software did to enables and flags
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            ctl_reg  <= 8'h00;
            seen_reg <= 1'b0;
            clr_reg  <= 1'b0;
            cwr_reg  <= 1'b0;
        end else begin
            ctl_reg  <= ctl_wr ? WDATA_IN : ctl_reg;
            seen_reg <= fl_rd | (seen_reg & ~fl_wr);
            clr_reg  <= fl_wr & seen_reg;
            cwr_reg  <= ctl_wr;
        end
    end
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    rsv_flags_a: assert property (fl_rd |=> RDATA_OUT[4])
        else $error("flags bit 4 read as zero");
    rsv_trig_a: assert property (RD_IN && ADDR_IN == `ECT_OFF_TRIG_CLK
        |=> (RDATA_OUT & 8'hE2) == 8'hE2) else $error("trigger reserved bits not one");
    reset_quiet_a: assert property ($rose(RESET_N_IN) |-> !WAVEFORM_OUT &&
        !IRQ_MATCH_A_OUT && !IRQ_MATCH_B_OUT && !IRQ_OVERFLOW_OUT) else $error("busy after reset");
    irq_a_en_a: assert property (IRQ_MATCH_A_OUT |-> ctl_reg[6])
        else $error("match A request while disabled");
    irq_b_en_a: assert property (IRQ_MATCH_B_OUT |-> ctl_reg[7])
        else $error("match B request while disabled");
    ovf_en_a: assert property (IRQ_OVERFLOW_OUT |-> ctl_reg[5])
        else $error("overflow request while disabled");
    a_clear_a: assert property ($fell(IRQ_MATCH_A_OUT) |-> clr_reg || cwr_reg)
        else $error("match A request dropped without armed clear");
    b_clear_a: assert property ($fell(IRQ_MATCH_B_OUT) |-> clr_reg || cwr_reg)
        else $error("match B request dropped without armed clear");
    ovf_clear_a: assert property ($fell(IRQ_OVERFLOW_OUT) |-> clr_reg || cwr_reg)
        else $error("overflow request dropped without armed clear");
    keep_one_a: assert property (fl_wr && WDATA_IN[6] && IRQ_MATCH_A_OUT
        |=> IRQ_MATCH_A_OUT) else $error("match A flag lost on write of one");
    cover property (fl_wr && IRQ_MATCH_A_OUT);
    cover property ($rose(IRQ_OVERFLOW_OUT));
    cover property ($rose(WAVEFORM_OUT));
endmodule : ect_timer_checker

bind ect_timer ect_timer_checker chk (.REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .WAVEFORM_OUT(WAVEFORM_OUT), .IRQ_MATCH_A_OUT(IRQ_MATCH_A_OUT),
    .IRQ_MATCH_B_OUT(IRQ_MATCH_B_OUT), .IRQ_OVERFLOW_OUT(IRQ_OVERFLOW_OUT));

// File: tb/test_eight_bit_compare_timer.sv
// Self-checking bench for the compare timer
`timescale 1ns/1ps
`include "ect_map.svh"
module test_eight_bit_compare_timer;
    logic       clk, rst_n, wr, rd;              // Clock, reset, strobes
    logic [2:0] addr;                            // Register address
    logic [7:0] wdata, rdata, v;                 // Bus data, scratch
    logic       ext_clk, ctr_rst, trig, wave;    // Pins
    logic       irq_a, irq_b, irq_ov;            // Requests
    int         fail_count = 0;                  // Mismatches
    int         n_checks = 0;                    // Comparisons
    int         i;                               // Wait counter
    ect_timer uut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .EXT_CLOCK_IN(ext_clk),
        .COUNTER_RESET_IN(ctr_rst), .COUNT_TRIGGER_IN(trig), .WAVEFORM_OUT(wave),
        .IRQ_MATCH_A_OUT(irq_a), .IRQ_MATCH_B_OUT(irq_b), .IRQ_OVERFLOW_OUT(irq_ov));
    ect_pins_model partner (.clk_in(clk), .ext_clk_out(ext_clk), .ctr_rst_out(ctr_rst),
        .trig_out(trig));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One clock, then let its updates land
    task tick();
        @(posedge clk);
        #1;
    endtask : tick
    task do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        tick();
    endtask : do_reset
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data lands in the cycle after the strobe and holds until the next read
    task rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task check_rd(input logic [2:0] a, input logic [7:0] exp);
        rd_reg(a, v);
        check(v, exp);
    endtask : check_rd
    // Reset values, reserved bits, unmapped place
    task t_regs();
        do_reset();
        check({7'h00, wave}, 8'h00);
        check_rd(`ECT_OFF_COUNTER, 8'h00);
        check_rd(`ECT_OFF_CONST_A, 8'hFF);
        check_rd(`ECT_OFF_CONST_B, 8'hFF);
        check_rd(`ECT_OFF_MAIN_CTL, 8'h00);
        check_rd(`ECT_OFF_FLAGS, 8'h10);
        check_rd(`ECT_OFF_TRIG_CLK, 8'hE2);
        check_rd(3'h6, 8'h00);
        wr_reg(`ECT_OFF_FLAGS, 8'h00);
        check_rd(`ECT_OFF_FLAGS, 8'h10);
        wr_reg(`ECT_OFF_TRIG_CLK, 8'h1D);
        check_rd(`ECT_OFF_TRIG_CLK, 8'hFF);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'hE0);
        check_rd(`ECT_OFF_MAIN_CTL, 8'hE0);
        wr_reg(3'h7, 8'h55);
        check_rd(`ECT_OFF_COUNTER, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    // Extra select picks divide by 8; code 100 stops
    task t_prescale();
        do_reset();
        wr_reg(`ECT_OFF_TRIG_CLK, 8'h01);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h01);
        repeat (80) tick();
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h04);
        rd_reg(`ECT_OFF_COUNTER, v);
        check({7'h00, v >= 8'h09 && v <= 8'h0C}, 8'h01);
        repeat (40) tick();
        check_rd(`ECT_OFF_COUNTER, v);
        $display("t_prescale done");
    endtask : t_prescale
    // Toggle on match A, clear on A, flag clear protocol
    task t_compare();
        do_reset();
        wr_reg(`ECT_OFF_CONST_A, 8'h05);
        wr_reg(`ECT_OFF_FLAGS, 8'h03);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h49);
        for (i = 0; i < 300 && irq_a !== 1'b1; i++) tick();
        check({6'h00, irq_a, wave}, 8'h03);
        for (i = 0; i < 60 && wave !== 1'b0; i++) tick();
        check({7'h00, i >= 20 && i <= 28}, 8'h01);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h48);
        wr_reg(`ECT_OFF_FLAGS, 8'h43);
        wr_reg(`ECT_OFF_FLAGS, 8'h03);
        check({7'h00, irq_a}, 8'h01);
        check_rd(`ECT_OFF_FLAGS, 8'h53);
        wr_reg(`ECT_OFF_FLAGS, 8'h03);
        tick();
        check({7'h00, irq_a}, 8'h00);
        $display("t_compare done");
    endtask : t_compare
    // Wrap on external rising edges
    task t_overflow();
        do_reset();
        wr_reg(`ECT_OFF_COUNTER, 8'hFE);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'hA5);
        partner.ext_pulses(2, 4);
        repeat (8) tick();
        check_rd(`ECT_OFF_COUNTER, 8'h00);
        check({6'h00, irq_ov, irq_b}, 8'h03);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'hA0);
        check_rd(`ECT_OFF_FLAGS, 8'hF0);
        wr_reg(`ECT_OFF_FLAGS, 8'hDF);
        check_rd(`ECT_OFF_FLAGS, 8'hDF);
        check({6'h00, irq_ov, irq_b}, 8'h01);
        $display("t_overflow done");
    endtask : t_overflow
    // Clear from the reset pin
    task t_pin_reset();
        do_reset();
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h19);
        repeat (40) tick();
        partner.rst_pulse();
        repeat (4) tick();
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h18);
        rd_reg(`ECT_OFF_COUNTER, v);
        check({7'h00, v < 8'h04}, 8'h01);
        $display("t_pin_reset done");
    endtask : t_pin_reset
    // Falling-edge start, drive high on B, halt after clear
    task t_trigger();
        do_reset();
        wr_reg(`ECT_OFF_CONST_B, 8'h03);
        wr_reg(`ECT_OFF_FLAGS, 8'h08);
        wr_reg(`ECT_OFF_TRIG_CLK, 8'h14);
        wr_reg(`ECT_OFF_MAIN_CTL, 8'h11);
        partner.set_trig(1'b1);
        repeat (40) tick();
        check_rd(`ECT_OFF_COUNTER, 8'h00);
        partner.set_trig(1'b0);
        for (i = 0; i < 100 && wave !== 1'b1; i++) tick();
        check({7'h00, wave}, 8'h01);
        repeat (40) tick();
        check_rd(`ECT_OFF_COUNTER, 8'h00);
        $display("t_trigger done");
    endtask : t_trigger
    task conclude();
        $display("Checks made: %0d, mismatches: %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        rst_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        t_regs();
        t_prescale();
        t_compare();
        t_overflow();
        t_pin_reset();
        t_trigger();
        conclude();
    end
    // Watchdog, well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule : test_eight_bit_compare_timer
